//--- tis_consts.svh
// constants of the touch i2c register slave: addresses, widths, counts
// assumes inclusion by bare name from every file that needs them
`ifndef TIS_CONSTS_SVH
`define TIS_CONSTS_SVH

// 7-bit target addresses of the two selectable pairs
`define TIS_ADDR_MAIN 7'h5d
`define TIS_ADDR_ALT 7'h14
// pointer and data widths
`define TIS_PTR_W 16
`define TIS_DATA_W 8
// write fifo shape: pointer plus data byte per word
`define TIS_FIFO_DEPTH 16
`define TIS_FIFO_W 24
// serial bit count of one byte
`define TIS_BIT_LAST 4'h8
`define TIS_BIT_ONE 4'h1
`define TIS_BIT_ZERO 4'h0
// link edges to wait before the strap level is taken
`define TIS_STRAP_WAIT 2'h3
// highest serial rate served, in kbit/s
`define TIS_MAX_KBPS 400
// reset values
`define TIS_PTR_RST 16'h0000
`define TIS_BYTE_RST 8'h00

`endif

//--- tis_fifo.sv
// dual-clock fifo with gray-coded pointers, valid and ready on both sides
// assumes depth is a power of two and both resets are asynchronous active low
`timescale 1ns/1ps

module tis_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic wr_clk_in,
   input wire logic wr_rst_n_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic rd_clk_in,
   input wire logic rd_rst_n_in,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   // pointers carry one extra bit to tell full from empty
   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] far_s1;
      logic [AW:0] far_s2;
   } tis_fptr_t;

   logic [WIDTH-1:0] mem [DEPTH]; // storage, written in the write domain only
   tis_fptr_t w_reg, w_next; // write side state
   tis_fptr_t r_reg, r_next; // read side state
   logic do_wr;
   logic do_rd;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction

   // full compares against the read pointer with its top two bits inverted
   assign wr_ready_out = (w_reg.gray != {~w_reg.far_s2[AW:AW-1], w_reg.far_s2[AW-2:0]});
   assign rd_valid_out = (r_reg.gray != r_reg.far_s2);
   assign rd_data_out = mem[r_reg.bin[AW-1:0]];
   assign do_wr = wr_valid_in & wr_ready_out;
   assign do_rd = rd_valid_out & rd_ready_in;

   // next write pointer; far pointer crosses through two flops
   always_comb
   begin
      w_next = w_reg;
      w_next.far_s1 = r_reg.gray;
      w_next.far_s2 = w_reg.far_s1;
      if (do_wr)
      begin
         w_next.bin = w_reg.bin + 1'b1;
         w_next.gray = bin2gray(w_next.bin);
      end
   end

   // next read pointer
   always_comb
   begin
      r_next = r_reg;
      r_next.far_s1 = w_reg.gray;
      r_next.far_s2 = r_reg.far_s1;
      if (do_rd)
      begin
         r_next.bin = r_reg.bin + 1'b1;
         r_next.gray = bin2gray(r_next.bin);
      end
   end

   // write domain registers
   always_ff @(posedge wr_clk_in or negedge wr_rst_n_in)
   begin
      if (!wr_rst_n_in)
         w_reg <= '0;
      else
         w_reg <= w_next;
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge wr_clk_in)
   begin
      if (do_wr)
         mem[w_reg.bin[AW-1:0]] <= wr_data_in;
   end

   // read domain registers
   always_ff @(posedge rd_clk_in or negedge rd_rst_n_in)
   begin
      if (!rd_rst_n_in)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end
endmodule

//--- tis_host_model.sv
// host i2c master model for the serial pins of the touch target
// assumes a 40 MHz clk_in; one bit takes 100 cycles, 400 kbit/s
`timescale 1ns/1ps

module tis_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // quarter bit: 625 ns keeps scl low and high above their minimum
   localparam int QTR = 25;

   // bus idle: scl high, sda left to its pull-up
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic qwait();
      repeat (QTR) @(posedge clk_in);
      #1;
   endtask

   // start, also repeated: sda falls with scl high
   task automatic start();
      sda_low_out = 1'b0;
      qwait();
      scl_out = 1'b1;
      qwait();
      sda_low_out = 1'b1;
      qwait();
      scl_out = 1'b0;
      qwait();
   endtask

   // stop: sda rises with scl high
   task automatic stop();
      sda_low_out = 1'b1;
      qwait();
      scl_out = 1'b1;
      qwait();
      sda_low_out = 1'b0;
      qwait();
   endtask

   // one clock: data set while scl low, sampled mid high
   task automatic bit_xfer(input logic b, output logic s);
      sda_low_out = !b;
      qwait();
      scl_out = 1'b1;
      qwait();
      s = sda_in;
      qwait();
      scl_out = 1'b0;
      qwait();
   endtask

   // byte out msb first; ninth clock brings the target's ack
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], s);
      bit_xfer(1'b1, s);
      ack = !s;
   endtask

   // byte in msb first, then ack or nack
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(1'b1, s);
         d[i] = s;
      end
      bit_xfer(!ack, s);
   endtask
endmodule

//--- tis_monitor.sv
// checker of the touch i2c target: serial drive, strap and core ports
// assumes a bind to tis_top and sees only its ports
`timescale 1ns/1ps
`include "tis_consts.svh"

module tis_monitor (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_out_out,
   input wire logic sda_oe_out,
   input wire logic addr_sel_in,
   input wire logic addr_alt_out,
   input wire logic wr_valid_out,
   input wire logic [`TIS_PTR_W-1:0] wr_addr_out,
   input wire logic [`TIS_DATA_W-1:0] wr_data_out,
   input wire logic wr_ready_in,
   input wire logic rd_en_out,
   input wire logic [`TIS_PTR_W-1:0] rd_addr_out
);
   logic [3:0] lcnt_reg;

   // counter lets the strap checks wait out the synchroniser
   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         lcnt_reg <= 4'h0;
      else if (lcnt_reg != 4'hf)
         lcnt_reg <= lcnt_reg + 4'h1;
   end

   property p_oe_scl_low;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("sda drive moved while scl high");

   property p_oe_after_fall;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      $rose(sda_oe_out) |-> ($past(scl_in, 2) == 1'b0);
   endproperty
   a_oe_after_fall: assert property (p_oe_after_fall)
      else $error("ack drive before settled scl fall");

   property p_open_drain;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      sda_oe_out |-> (sda_out_out == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("sda driven high");

   property p_no_early;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      (lcnt_reg < 4'h6) |-> !sda_oe_out;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("sda driven too early");

   property p_strap;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      (lcnt_reg == 4'h9) |-> (addr_alt_out == addr_sel_in);
   endproperty
   a_strap: assert property (p_strap)
      else $error("address pair differs from strap");

   property p_strap_hold;
      @(posedge link_clk_in) disable iff (!reset_n_in)
      (lcnt_reg > 4'h9) |-> $stable(addr_alt_out);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("address pair moved");

   property p_wr_hold;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      wr_valid_out && !wr_ready_in |=>
         wr_valid_out && $stable(wr_addr_out) && $stable(wr_data_out);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("stalled write word not held");

   property p_rd_pulse;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      rd_en_out |=> !rd_en_out;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe too long");

   property p_rd_alone;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      rd_en_out |-> !wr_valid_out;
   endproperty
   a_rd_alone: assert property (p_rd_alone)
      else $error("read issued with a write pending");

   property p_rd_addr;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      $changed(rd_addr_out) |-> rd_en_out;
   endproperty
   a_rd_addr: assert property (p_rd_addr)
      else $error("read address moved alone");
endmodule

bind tis_top tis_monitor u_mon (.core_clk_in, .reset_n_in, .link_clk_in, .scl_in,
   .sda_out_out, .sda_oe_out, .addr_sel_in, .addr_alt_out, .wr_valid_out, .wr_addr_out,
   .wr_data_out, .wr_ready_in, .rd_en_out, .rd_addr_out);

//--- tis_pkg.sv
// types of the touch i2c register slave: state encodings and state structs
// assumes tis_consts.svh supplies the widths
`include "tis_consts.svh"

package tis_pkg;

   // link side protocol states
   typedef enum logic [3:0] {
      L_IDLE, L_ADDR, L_ADDR_ACK, L_PTRH, L_PTRH_ACK, L_PTRL, L_PTRL_ACK,
      L_WDATA, L_WDATA_ACK, L_TX, L_TX_ACK
   } tis_lstate_t;

   // core side read service states
   typedef enum logic [1:0] {C_IDLE, C_ISSUE, C_CAPT} tis_cstate_t;

   // all state of the link domain
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_prev;
      logic sda_s1;
      logic sda_s2;
      logic sda_prev;
      logic sel_s1;
      logic sel_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic alt_addr;
      tis_lstate_t state;
      logic [3:0] bit_cnt;
      logic [`TIS_DATA_W-1:0] shift;
      logic rw;
      logic [`TIS_PTR_W-1:0] ptr;
      logic sda_oe;
      logic req_tog;
      logic [`TIS_PTR_W-1:0] req_addr;
      logic ack_s1;
      logic ack_s2;
      logic ack_prev;
      logic [`TIS_DATA_W-1:0] rdata;
      logic push;
      logic [`TIS_FIFO_W-1:0] push_data;
   } tis_link_t;

   // all state of the core domain
   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_prev;
      logic pend;
      tis_cstate_t state;
      logic ack_tog;
      logic [`TIS_DATA_W-1:0] rdata;
      logic rd_en;
      logic [`TIS_PTR_W-1:0] rd_addr;
      logic wv;
      logic [`TIS_PTR_W-1:0] waddr;
      logic [`TIS_DATA_W-1:0] wdata;
   } tis_core_t;

endpackage

//--- tis_tb.sv
// self-checking bench of the touch i2c target and a host model
// assumes the design, monitor and host model files compile first
`timescale 1ns/1ps
`include "tis_consts.svh"
`define CHK(nm, ex, got) \
   begin \
      compares++; \
      if ((got) !== (ex)) \
      begin \
         err_total++; \
         $display("Error %s expected %h seen %h", nm, ex, got); \
      end \
   end

module tb;
   typedef struct {logic [15:0] ptr; int nw; logic [7:0] d0; int nr;} tis_row_t;
   logic core_clk_in, link_clk_in, reset_n_in, scl_in, m_low, addr_sel_in;
   logic wr_ready_in, sda_out_out, sda_oe_out, addr_alt_out, wr_valid_out, rd_en_out;
   logic [15:0] wr_addr_out, rd_addr_out;
   logic [7:0] wr_data_out, rd_data_in;
   wire sda_in;
   int err_total = 0;
   int compares = 0;
   int n_ok;
   logic a;
   logic [7:0] mem [0:255];
   logic [7:0] exp_mem [0:255];
   logic [15:0] got_a[$];
   logic [7:0] got_d[$];
   // rows: write nw bytes at ptr, read nr back
   tis_row_t rows[4] = '{'{16'h8047, 1, 8'h55, 1}, '{16'h12fe, 2, 8'ha0, 3},
      '{16'hffff, 2, 8'h3c, 2}, '{16'h0040, 0, 8'h00, 3}};

   // pulled up; low while either side pulls
   assign sda_in = !m_low && (!sda_oe_out || sda_out_out);

   initial
   begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = !core_clk_in;
   end

   // link clock: free running, unrelated phase
   initial
   begin
      link_clk_in = 1'b0;
      #3.7;
      forever #7.5 link_clk_in = !link_clk_in;
   end

   tis_top u_dut (.core_clk_in, .reset_n_in, .link_clk_in, .scl_in, .sda_in, .sda_out_out,
      .sda_oe_out, .addr_sel_in, .addr_alt_out, .wr_valid_out, .wr_addr_out, .wr_data_out,
      .wr_ready_in, .rd_en_out, .rd_addr_out, .rd_data_in);
   tis_host_model u_m (.clk_in(core_clk_in), .sda_in(sda_in), .scl_out(scl_in),
      .sda_low_out(m_low));

   // core register file: stores words, answers reads
   always @(posedge core_clk_in)
   begin
      if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1)
      begin
         got_a.push_back(wr_addr_out);
         got_d.push_back(wr_data_out);
         mem[wr_addr_out[7:0]] = wr_data_out;
      end
      #1;
      if (rd_en_out === 1'b1)
         rd_data_in = mem[rd_addr_out[7:0]];
   end

   task automatic do_reset(input logic sel);
      @(posedge core_clk_in);
      #1;
      reset_n_in = 1'b0;
      addr_sel_in = sel;
      repeat (12) @(posedge core_clk_in);
      #1;
      reset_n_in = 1'b1;
      repeat (20) @(posedge core_clk_in);
      #1;
   endtask

   task automatic snd(input logic [7:0] b, input logic ea, input string nm);
      logic ak;
      u_m.send_byte(b, ak);
      `CHK(nm, ea, ak)
   endtask

   task automatic set_ptr(input logic [6:0] ad, input logic [15:0] p);
      u_m.start();
      snd({ad, 1'b0}, 1'b1, "addr w ack");
      snd(p[15:8], 1'b1, "ptr hi ack");
      snd(p[7:0], 1'b1, "ptr lo ack");
   endtask

   // repeated start, read address, n bytes, last nacked
   task automatic rd_seq(input logic [6:0] ad, input logic [15:0] p, input int n);
      logic [7:0] d;
      u_m.start();
      snd({ad, 1'b1}, 1'b1, "addr r ack");
      for (int k = 0; k < n; k++)
      begin
         u_m.recv_byte(k < n - 1, d);
         `CHK("read byte", exp_mem[8'(p + 16'(k))], d)
      end
      u_m.stop();
   endtask

   task automatic wr_seq(input logic [15:0] p, input int n, input logic [7:0] d0);
      set_ptr(`TIS_ADDR_MAIN, p);
      for (int k = 0; k < n; k++)
      begin
         snd(d0 + 8'(k), 1'b1, "data ack");
         exp_mem[8'(p + 16'(k))] = d0 + 8'(k);
      end
      u_m.stop();
   endtask

   // words reach the core in order from ptr
   task automatic chk_wr(input logic [15:0] p, input int n, input logic [7:0] d0);
      int t = 0;
      while (got_a.size() < n && t < 500)
      begin
         @(posedge core_clk_in);
         t++;
      end
      `CHK("write count", n, got_a.size())
      for (int k = 0; k < n && k < got_a.size(); k++)
      begin
         `CHK("write addr", p + 16'(k), got_a[k])
         `CHK("write data", d0 + 8'(k), got_d[k])
      end
      got_a.delete();
      got_d.delete();
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      reset_n_in = 1'b0;
      addr_sel_in = 1'b0;
      wr_ready_in = 1'b1;
      rd_data_in = 8'h00;
      for (int i = 0; i < 256; i++)
      begin
         mem[i] = 8'(i) ^ 8'ha5;
         exp_mem[i] = 8'(i) ^ 8'ha5;
      end
      do_reset(1'b0);
      `CHK("idle drive", 1'b0, sda_oe_out)
      `CHK("pair main", 1'b0, addr_alt_out)
      foreach (rows[i])
      begin
         if (rows[i].nw > 0)
         begin
            wr_seq(rows[i].ptr, rows[i].nw, rows[i].d0);
            chk_wr(rows[i].ptr, rows[i].nw, rows[i].d0);
         end
         set_ptr(`TIS_ADDR_MAIN, rows[i].ptr);
         rd_seq(`TIS_ADDR_MAIN, rows[i].ptr, rows[i].nr);
         $display("test row %0d done", i);
      end
      // no pointer write: read continues at kept pointer
      rd_seq(`TIS_ADDR_MAIN, 16'h0043, 1);
      $display("test pointer kept done");
      // foreign address: no ack, rest of the frame ignored
      u_m.start();
      snd({`TIS_ADDR_ALT, 1'b0}, 1'b0, "foreign addr nack");
      snd(8'h12, 1'b0, "ignored byte nack");
      u_m.stop();
      `CHK("no write after mismatch", 0, got_a.size())
      $display("test mismatch done");
      // mid-run reset, strap high: other pair
      do_reset(1'b1);
      `CHK("pair alt", 1'b1, addr_alt_out)
      u_m.start();
      snd({`TIS_ADDR_MAIN, 1'b1}, 1'b0, "main addr nack");
      u_m.stop();
      $display("test strap done");
      // core stalls: fifo fills, then bytes are refused until start
      wr_ready_in = 1'b0;
      set_ptr(`TIS_ADDR_ALT, 16'h0080);
      n_ok = 0;
      for (int k = 0; k < 18; k++)
      begin
         u_m.send_byte(8'h40 + 8'(k), a);
         if (a === 1'b1 && k == n_ok)
            n_ok++;
      end
      u_m.stop();
      `CHK("bytes taken before full", `TIS_FIFO_DEPTH + 1, n_ok)
      wr_ready_in = 1'b1;
      chk_wr(16'h0080, n_ok, 8'h40);
      $display("test fifo full done");
      wrap_up();
   end

   // watchdog: the run needs about 61000 core cycles
   initial
   begin
      repeat (95000) @(posedge core_clk_in);
      err_total++;
      $display("Error watchdog expected finish seen hang");
      wrap_up();
   end
endmodule

//--- tis_top.sv
// i2c target port of a touch controller: serial side on the link clock,
// register side on the core clock, write words pass a 16-word fifo
// assumes scl and sda come from pins with pull-ups, and the core side
// answers rd_en_out with rd_data_in one core cycle later
`timescale 1ns/1ps
`include "tis_consts.svh"

module tis_top (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out_out,
   output logic sda_oe_out,
   input wire logic addr_sel_in,
   output logic addr_alt_out,
   output logic wr_valid_out,
   output logic [`TIS_PTR_W-1:0] wr_addr_out,
   output logic [`TIS_DATA_W-1:0] wr_data_out,
   input wire logic wr_ready_in,
   output logic rd_en_out,
   output logic [`TIS_PTR_W-1:0] rd_addr_out,
   input wire logic [`TIS_DATA_W-1:0] rd_data_in
);
   import tis_pkg::*;

   tis_link_t l_reg, l_next; // link domain state
   tis_core_t c_reg, c_next; // core domain state
   logic fifo_wr_ready; // write fifo has room
   logic fifo_rd_valid; // write fifo holds a word
   logic fifo_rd_ready; // output stage can take a word
   logic [`TIS_FIFO_W-1:0] fifo_rd_data;
   // derived link events, all from synchronised pins
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [6:0] own_addr;

   // pointer increment, shared by writes and reads
   function automatic logic [`TIS_PTR_W-1:0] ptr_inc(input logic [`TIS_PTR_W-1:0] p);
      ptr_inc = p + `TIS_PTR_W'(1);
   endfunction

   // the pins are only read after the second flop of each synchroniser
   assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_prev;
   assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_prev;
   assign start_seen = l_reg.scl_s2 & l_reg.scl_prev & l_reg.sda_prev & ~l_reg.sda_s2;
   assign stop_seen = l_reg.scl_s2 & l_reg.scl_prev & ~l_reg.sda_prev & l_reg.sda_s2;
   assign own_addr = l_reg.alt_addr ? `TIS_ADDR_ALT : `TIS_ADDR_MAIN;

   // link domain next state
   always_comb
   begin
      l_next = l_reg;
      l_next.scl_s1 = scl_in;
      l_next.scl_s2 = l_reg.scl_s1;
      l_next.scl_prev = l_reg.scl_s2;
      l_next.sda_s1 = sda_in;
      l_next.sda_s2 = l_reg.sda_s1;
      l_next.sda_prev = l_reg.sda_s2;
      l_next.sel_s1 = addr_sel_in;
      l_next.sel_s2 = l_reg.sel_s1;
      l_next.ack_s1 = c_reg.ack_tog;
      l_next.ack_s2 = l_reg.ack_s1;
      l_next.ack_prev = l_reg.ack_s2;
      l_next.push = 1'b0;
      // read byte is taken once the toggle has settled
      if (l_reg.ack_s2 != l_reg.ack_prev)
         l_next.rdata = c_reg.rdata;
      // strap level is caught a few edges after reset release
      if (!l_reg.strap_done)
      begin
         if (l_reg.strap_cnt == `TIS_STRAP_WAIT)
         begin
            l_next.strap_done = 1'b1;
            l_next.alt_addr = l_reg.sel_s2;
         end
         else
            l_next.strap_cnt = l_reg.strap_cnt + 2'h1;
      end
      else if (start_seen)
      begin
         // any start, repeated too, reopens address reception
         l_next.state = L_ADDR;
         l_next.bit_cnt = `TIS_BIT_ZERO;
         l_next.sda_oe = 1'b0;
      end
      else if (stop_seen)
      begin
         // pointer is left untouched so a later read continues
         l_next.state = L_IDLE;
         l_next.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         // sampling happens on the rising edge while the line is stable
         unique case (l_reg.state)
            L_ADDR, L_PTRH, L_PTRL, L_WDATA:
            begin
               if (l_reg.bit_cnt != `TIS_BIT_LAST)
               begin
                  l_next.shift = {l_reg.shift[`TIS_DATA_W-2:0], l_reg.sda_s2};
                  l_next.bit_cnt = l_reg.bit_cnt + `TIS_BIT_ONE;
               end
            end
            L_TX_ACK:
            begin
               // master ack asks for the next byte; nack ends the read
               if (!l_reg.sda_s2)
               begin
                  l_next.bit_cnt = `TIS_BIT_ONE;
                  l_next.req_addr = l_reg.ptr;
                  l_next.req_tog = ~l_reg.req_tog;
               end
               else
                  l_next.state = L_IDLE;
            end
            default:
            begin
               l_next.state = l_reg.state;
            end
         endcase
      end
      else if (scl_fall)
      begin
         // the driven line only changes just after scl falls
         unique case (l_reg.state)
            L_ADDR:
            begin
               if (l_reg.bit_cnt == `TIS_BIT_LAST)
               begin
                  if (l_reg.shift[7:1] == own_addr)
                  begin
                     l_next.sda_oe = 1'b1;
                     l_next.rw = l_reg.shift[0];
                     l_next.state = L_ADDR_ACK;
                     // prefetch the first read byte during the ack bit
                     if (l_reg.shift[0])
                     begin
                        l_next.req_addr = l_reg.ptr;
                        l_next.req_tog = ~l_reg.req_tog;
                     end
                  end
                  else
                     l_next.state = L_IDLE;
               end
            end
            L_PTRH:
            begin
               if (l_reg.bit_cnt == `TIS_BIT_LAST)
               begin
                  l_next.ptr[15:8] = l_reg.shift;
                  l_next.sda_oe = 1'b1;
                  l_next.state = L_PTRH_ACK;
               end
            end
            L_PTRL:
            begin
               if (l_reg.bit_cnt == `TIS_BIT_LAST)
               begin
                  l_next.ptr[7:0] = l_reg.shift;
                  l_next.sda_oe = 1'b1;
                  l_next.state = L_PTRL_ACK;
               end
            end
            L_WDATA:
            begin
               if (l_reg.bit_cnt == `TIS_BIT_LAST)
               begin
                  // a full fifo refuses the byte with a nack instead of losing it
                  if (fifo_wr_ready)
                  begin
                     l_next.push = 1'b1;
                     l_next.push_data = {l_reg.ptr, l_reg.shift};
                     l_next.ptr = ptr_inc(l_reg.ptr);
                     l_next.sda_oe = 1'b1;
                     l_next.state = L_WDATA_ACK;
                  end
                  else
                     l_next.state = L_IDLE;
               end
            end
            L_ADDR_ACK:
            begin
               l_next.sda_oe = 1'b0;
               l_next.bit_cnt = `TIS_BIT_ZERO;
               if (l_reg.rw)
               begin
                  l_next.shift = l_reg.rdata;
                  l_next.sda_oe = ~l_reg.rdata[7];
                  l_next.bit_cnt = `TIS_BIT_ONE;
                  l_next.ptr = ptr_inc(l_reg.ptr);
                  l_next.state = L_TX;
               end
               else
                  l_next.state = L_PTRH;
            end
            L_PTRH_ACK:
            begin
               l_next.sda_oe = 1'b0;
               l_next.bit_cnt = `TIS_BIT_ZERO;
               l_next.state = L_PTRL;
            end
            L_PTRL_ACK, L_WDATA_ACK:
            begin
               l_next.sda_oe = 1'b0;
               l_next.bit_cnt = `TIS_BIT_ZERO;
               l_next.state = L_WDATA;
            end
            L_TX:
            begin
               if (l_reg.bit_cnt == `TIS_BIT_LAST)
               begin
                  // release the line so the master can answer
                  l_next.sda_oe = 1'b0;
                  l_next.bit_cnt = `TIS_BIT_ZERO;
                  l_next.state = L_TX_ACK;
               end
               else
               begin
                  l_next.shift = {l_reg.shift[`TIS_DATA_W-2:0], 1'b0};
                  l_next.sda_oe = ~l_reg.shift[6];
                  l_next.bit_cnt = l_reg.bit_cnt + `TIS_BIT_ONE;
               end
            end
            L_TX_ACK:
            begin
               // the prefetched byte has had a full scl high time to arrive
               if (l_reg.bit_cnt == `TIS_BIT_ONE)
               begin
                  l_next.shift = l_reg.rdata;
                  l_next.sda_oe = ~l_reg.rdata[7];
                  l_next.ptr = ptr_inc(l_reg.ptr);
                  l_next.state = L_TX;
               end
            end
            default:
            begin
               l_next.state = l_reg.state;
            end
         endcase
      end
   end

   // link domain registers; sda is only pulled low
   always_ff @(posedge link_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         l_reg <= '0;
         l_reg.scl_s1 <= 1'b1;
         l_reg.scl_s2 <= 1'b1;
         l_reg.scl_prev <= 1'b1;
         l_reg.sda_s1 <= 1'b1;
         l_reg.sda_s2 <= 1'b1;
         l_reg.sda_prev <= 1'b1;
         l_reg.state <= L_IDLE;
         l_reg.ptr <= `TIS_PTR_RST;
         l_reg.rdata <= `TIS_BYTE_RST;
      end
      else
         l_reg <= l_next;
   end

   // write words cross to the core clock through the fifo
   tis_fifo #(
      .WIDTH(`TIS_FIFO_W),
      .DEPTH(`TIS_FIFO_DEPTH)
   ) u_fifo (
      .wr_clk_in(link_clk_in),
      .wr_rst_n_in(reset_n_in),
      .wr_valid_in(l_reg.push),
      .wr_ready_out(fifo_wr_ready),
      .wr_data_in(l_reg.push_data),
      .rd_clk_in(core_clk_in),
      .rd_rst_n_in(reset_n_in),
      .rd_valid_out(fifo_rd_valid),
      .rd_ready_in(fifo_rd_ready),
      .rd_data_out(fifo_rd_data)
   );

   // the output stage takes a word when empty or being emptied
   assign fifo_rd_ready = ~c_reg.wv | wr_ready_in;

   // core domain next state
   always_comb
   begin
      c_next = c_reg;
      c_next.req_s1 = l_reg.req_tog;
      c_next.req_s2 = c_reg.req_s1;
      c_next.req_prev = c_reg.req_s2;
      c_next.rd_en = 1'b0;
      // a new read request is held until earlier writes have drained
      if (c_reg.req_s2 != c_reg.req_prev)
         c_next.pend = 1'b1;
      // write output stage
      if (fifo_rd_valid && fifo_rd_ready)
      begin
         c_next.wv = 1'b1;
         c_next.waddr = fifo_rd_data[`TIS_FIFO_W-1:`TIS_DATA_W];
         c_next.wdata = fifo_rd_data[`TIS_DATA_W-1:0];
      end
      else if (wr_ready_in)
         c_next.wv = 1'b0;
      // read service: issue, wait one cycle, capture, answer by toggle
      unique case (c_reg.state)
         C_IDLE:
         begin
            if (c_reg.pend && !fifo_rd_valid && !c_reg.wv)
            begin
               c_next.pend = (c_reg.req_s2 != c_reg.req_prev);
               c_next.rd_en = 1'b1;
               c_next.rd_addr = l_reg.req_addr;
               c_next.state = C_ISSUE;
            end
         end
         C_ISSUE:
         begin
            c_next.state = C_CAPT;
         end
         C_CAPT:
         begin
            c_next.rdata = rd_data_in;
            c_next.ack_tog = ~c_reg.ack_tog;
            c_next.state = C_IDLE;
         end
      endcase
   end

   // core domain registers
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         c_reg <= '0;
         c_reg.state <= C_IDLE;
      end
      else
         c_reg <= c_next;
   end

   // outputs straight from flops; open-drain data stays low
   assign sda_out_out = l_reg.push & 1'b0;
   assign sda_oe_out = l_reg.sda_oe;
   assign addr_alt_out = l_reg.alt_addr;
   assign wr_valid_out = c_reg.wv;
   assign wr_addr_out = c_reg.waddr;
   assign wr_data_out = c_reg.wdata;
   assign rd_en_out = c_reg.rd_en;
   assign rd_addr_out = c_reg.rd_addr;
endmodule
